// file: src/ir_carrier_modulation_timer.sv
/*
 * infrared carrier generation and modulation timer with an ahb-lite
 * register slave, one level interrupt and receive edge capture.
 * assumes one clock, synchronous active-low reset, the receive pin
 * asynchronous to clk_in, and a single ahb-lite master.
 */
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ir_carrier_modulation_timer
   import ir_timer_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // ahb-lite slave
   input  wire logic        hsel_in,
   input  wire logic [7:0]  haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic [31:0]      hrdata_out,
   // infrared pins
   input  wire logic        ir_receive_pin_in,
   output logic             ir_transmit_pin_out,
   output logic             ir_transmit_pin_oe_out,
   output logic             envelope_output_pin_out,
   // interrupt
   output logic             irq_out
);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   logic [ctrl_width-1:0] ctrl_reg;
   logic [15:0]           carrier_timing_register_reg;
   logic [15:0]           modulator_time_register_reg;
   logic [15:0]           interval_counter_reg;
   logic [1:0]            status_reg;
   logic [1:0]            mask_reg;
   logic [1:0]            power_control_register_reg;
   logic [7:0]            addr_reg;
   logic                  wr_pending_reg;
   logic [31:0]           rdata_reg;

   // transmit state
   logic [15:0] carrier_latched_reg;
   logic        data_latched_reg;
   logic        pol_latched_reg;
   logic        tx_active_reg;
   logic        start_seen_reg;
   logic [7:0]  prescale_reg;
   logic [7:0]  phase_count_reg;
   logic        carrier_high_reg;
   logic        tx_pin_reg;
   logic        env_pin_reg;

   // receive state
   logic [2:0]  rx_sync_reg;
   logic        rx_level_reg;
   logic        rx_started_reg;
   logic [1:0]  space_count_reg;
   logic        space_flagged_reg;

   // ------------------------------------------------------------------
   // control decode
   // ------------------------------------------------------------------
   logic       ir_timer_enable;
   logic       transmit_mode_select;
   logic       counter_clock_select;
   logic       tx_polarity;
   logic       modulation_data_bit;
   logic       receive_count_reload;
   logic       burst_count_mode;
   logic [1:0] input_clock_divider;
   logic [1:0] receive_edge_select;
   logic [1:0] envelope_mode_field;

   assign ir_timer_enable      = ctrl_reg[enable_bit];
   assign transmit_mode_select = ctrl_reg[tx_mode_bit];
   assign counter_clock_select = ctrl_reg[clk_sel_bit];
   assign tx_polarity          = ctrl_reg[polarity_bit];
   assign modulation_data_bit  = ctrl_reg[data_bit];
   assign receive_count_reload = ctrl_reg[reload_bit];
   assign burst_count_mode     = ctrl_reg[burst_bit];
   assign input_clock_divider  = ctrl_reg[div_lsb+1:div_lsb];
   assign receive_edge_select  = ctrl_reg[edge_lsb+1:edge_lsb];
   assign envelope_mode_field  = ctrl_reg[env_lsb+1:env_lsb];

   logic tx_run;
   logic rx_run;
   logic tx_start;
   assign tx_run   = ir_timer_enable & transmit_mode_select;
   assign rx_run   = ir_timer_enable & ~transmit_mode_select;
   assign tx_start = tx_run & ~start_seen_reg;

   // ------------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------------
   logic addr_phase;
   logic wr_now;
   logic [31:0] rd_mux;
   assign addr_phase    = hsel_in & htrans_in[1] & hready_in;
   assign wr_now        = wr_pending_reg;
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign hrdata_out    = rdata_reg;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (haddr_in)
         ctrl_offset:    rd_mux[ctrl_width-1:0] = ctrl_reg;
         carrier_offset: rd_mux[15:0] = carrier_timing_register_reg;
         modtime_offset: rd_mux[15:0] = modulator_time_register_reg;
         counter_offset: rd_mux[15:0] = interval_counter_reg;
         status_offset:  rd_mux[1:0]  = status_reg;
         mask_offset:    rd_mux[1:0]  = mask_reg;
         power_offset:   rd_mux[1:0]  = power_control_register_reg;
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         addr_reg       <= 8'h00;
         wr_pending_reg <= 1'b0;
         rdata_reg      <= 32'h0000_0000;
      end else begin
         wr_pending_reg <= addr_phase & hwrite_in;
         if (addr_phase) begin
            addr_reg <= haddr_in;
         end
         if (addr_phase & ~hwrite_in) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------------
   // ir input clock and carrier generator
   // ------------------------------------------------------------------
   logic [7:0] div_mask;
   logic       irclk_tick;
   logic [7:0] high_len;
   logic [7:0] low_len;
   logic       carrier_tick;
   assign div_mask   = 8'((8'h01 << input_clock_divider) - 8'h01);
   assign irclk_tick = (prescale_reg & div_mask) == div_mask;
   assign high_len   = tx_run ? carrier_latched_reg[15:8] : carrier_timing_register_reg[15:8];
   assign low_len    = tx_run ? carrier_latched_reg[7:0] : carrier_timing_register_reg[7:0];
   assign carrier_tick = irclk_tick & ~carrier_high_reg & (phase_count_reg == low_len);

   always_ff @(posedge clk_in) begin
      if (!rstn_in || !ir_timer_enable || tx_start) begin
         prescale_reg     <= 8'h00;
         phase_count_reg  <= 8'h00;
         carrier_high_reg <= 1'b1;
      end else begin
         prescale_reg <= prescale_reg + 8'h01;
         if (irclk_tick) begin
            if (carrier_high_reg && phase_count_reg == high_len) begin
               carrier_high_reg <= 1'b0;
               phase_count_reg  <= 8'h00;
            end else if (!carrier_high_reg && phase_count_reg == low_len) begin
               carrier_high_reg <= 1'b1;
               phase_count_reg  <= 8'h00;
            end else begin
               phase_count_reg <= phase_count_reg + 8'h01;
            end
         end
      end
   end

   logic count_tick;
   assign count_tick = counter_clock_select ? irclk_tick : carrier_tick;

   // ------------------------------------------------------------------
   // receive pin synchroniser and edge qualification
   // ------------------------------------------------------------------
   logic rx_change;
   logic rx_rise;
   logic rx_fall;
   logic qual_edge;
   assign rx_change = (rx_sync_reg[1] == rx_sync_reg[2]) && (rx_sync_reg[2] != rx_level_reg);
   assign rx_rise   = rx_change & rx_sync_reg[2];
   assign rx_fall   = rx_change & ~rx_sync_reg[2];

   always_comb begin
      case (receive_edge_select)
         edge_falling: qual_edge = rx_fall;
         edge_rising:  qual_edge = rx_rise;
         default:      qual_edge = rx_change;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         rx_sync_reg  <= 3'h0;
         rx_level_reg <= 1'b0;
      end else begin
         rx_sync_reg <= {rx_sync_reg[1:0], ir_receive_pin_in};
         if (rx_sync_reg[1] == rx_sync_reg[2]) begin
            rx_level_reg <= rx_sync_reg[2];
         end
      end
   end

   // ------------------------------------------------------------------
   // interval counter, boundaries and receive capture
   // ------------------------------------------------------------------
   logic boundary;
   logic rx_capture;
   logic rx_overflow;
   logic space_detect;
   assign boundary    = tx_run & start_seen_reg & count_tick & (interval_counter_reg == 16'h0000);
   assign rx_capture  = rx_run & rx_started_reg & qual_edge;
   assign rx_overflow = rx_run & rx_started_reg & ~qual_edge & count_tick
                        & (interval_counter_reg == count_max);
   assign space_detect = rx_run & burst_count_mode & rx_started_reg & ~space_flagged_reg
                         & carrier_tick & (space_count_reg == space_periods - 2'h1);

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         start_seen_reg <= 1'b0;
         tx_active_reg  <= 1'b0;
      end else begin
         start_seen_reg <= tx_run;
         tx_active_reg  <= tx_run;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         interval_counter_reg <= 16'h0000;
         rx_started_reg       <= 1'b0;
      end else if (tx_start) begin
         interval_counter_reg <= modulator_time_register_reg;
         rx_started_reg       <= 1'b0;
      end else if (tx_run) begin
         if (boundary) begin
            interval_counter_reg <= modulator_time_register_reg;
         end else if (count_tick) begin
            interval_counter_reg <= interval_counter_reg - 16'h0001;
         end
      end else if (rx_run) begin
         if (!rx_started_reg) begin
            if (qual_edge) begin
               rx_started_reg       <= 1'b1;
               interval_counter_reg <= 16'h0000;
            end
         end else if (qual_edge && receive_count_reload) begin
            interval_counter_reg <= 16'h0000;
         end else if (count_tick) begin
            interval_counter_reg <= interval_counter_reg + 16'h0001;
         end
      end else begin
         rx_started_reg <= 1'b0;
      end
   end

   // space detection in burst mode counts carrier periods since the last edge
   always_ff @(posedge clk_in) begin
      if (!rstn_in || !rx_run || qual_edge) begin
         space_count_reg   <= 2'h0;
         space_flagged_reg <= 1'b0;
      end else if (carrier_tick) begin
         if (space_count_reg == space_periods - 2'h1) begin
            space_flagged_reg <= 1'b1;
         end else begin
            space_count_reg <= space_count_reg + 2'h1;
         end
      end
   end

   // ------------------------------------------------------------------
   // transmit latching and pins
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         carrier_latched_reg <= carrier_reset;
         data_latched_reg    <= 1'b0;
         pol_latched_reg     <= 1'b0;
      end else if (tx_start || boundary) begin
         carrier_latched_reg <= carrier_timing_register_reg;
         data_latched_reg    <= modulation_data_bit;
         pol_latched_reg     <= tx_polarity;
      end
   end

   logic carrier_wave;
   logic tx_level;
   assign carrier_wave = carrier_high_reg ^ pol_latched_reg;

   always_comb begin
      if (!tx_active_reg) begin
         tx_level = tx_polarity;
      end else if (envelope_mode_field == env_carrier) begin
         tx_level = carrier_wave;
      end else begin
         tx_level = data_latched_reg ? carrier_wave : pol_latched_reg;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         tx_pin_reg  <= 1'b0;
         env_pin_reg <= 1'b0;
      end else begin
         if (!ir_timer_enable) begin
            tx_pin_reg <= power_control_register_reg[manual_level_bit];
         end else begin
            tx_pin_reg <= tx_level;
         end
         if (tx_start || boundary) begin
            env_pin_reg <= modulation_data_bit ^ tx_polarity;
         end
      end
   end

   assign ir_transmit_pin_out     = tx_pin_reg;
   assign ir_transmit_pin_oe_out  = ir_timer_enable
                                    | power_control_register_reg[manual_oe_bit];
   assign envelope_output_pin_out = env_pin_reg;

   // ------------------------------------------------------------------
   // software registers (hardware update has priority)
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ctrl_reg                    <= ctrl_reset;
         carrier_timing_register_reg <= carrier_reset;
         mask_reg                    <= 2'h0;
         power_control_register_reg  <= 2'h0;
      end else begin
         if (wr_now) begin
            case (addr_reg)
               ctrl_offset:    ctrl_reg <= hwdata_in[ctrl_width-1:0];
               carrier_offset: carrier_timing_register_reg <= hwdata_in[15:0];
               mask_offset:    mask_reg <= hwdata_in[1:0];
               power_offset:   power_control_register_reg <= hwdata_in[1:0];
               default:        ;
            endcase
         end
         if (rx_capture && !burst_count_mode) begin
            ctrl_reg[data_bit] <= rx_rise;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         modulator_time_register_reg <= modtime_reset;
      end else if (rx_capture && burst_count_mode) begin
         modulator_time_register_reg <= modulator_time_register_reg + 16'h0001;
      end else if (rx_capture) begin
         modulator_time_register_reg <= interval_counter_reg;
      end else if (wr_now && addr_reg == modtime_offset) begin
         modulator_time_register_reg <= hwdata_in[15:0];
      end
   end

   // ------------------------------------------------------------------
   // status flags and interrupt
   // ------------------------------------------------------------------
   logic [1:0] flag_set;
   logic [1:0] flag_clr;
   assign flag_set[interval_flag_bit] = boundary | (rx_capture & ~burst_count_mode) | space_detect;
   assign flag_set[overflow_flag_bit] = rx_overflow;
   assign flag_clr = (wr_now && addr_reg == status_offset) ? hwdata_in[1:0] : 2'h0;

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         status_reg <= 2'h0;
      end else begin
         status_reg <= (status_reg & ~flag_clr) | flag_set;
      end
   end

   assign irq_out = |(status_reg & mask_reg);

endmodule

`default_nettype wire

// file: src/ir_timer_pkg.sv
/*
 * constants for the infrared carrier and modulation timer: register byte
 * offsets, control field positions, reset values and small encodings.
 * assumes a 32-bit byte-addressed ahb-lite register window.
 */
package ir_timer_pkg;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ctrl_offset      = 8'h00;
   localparam logic [7:0] carrier_offset   = 8'h04;
   localparam logic [7:0] modtime_offset   = 8'h08;
   localparam logic [7:0] counter_offset   = 8'h0C;
   localparam logic [7:0] status_offset    = 8'h10;
   localparam logic [7:0] mask_offset      = 8'h14;
   localparam logic [7:0] power_offset     = 8'h18;

   // ------------------------------------------------------------------
   // control register field positions
   // ------------------------------------------------------------------
   localparam int enable_bit      = 0;
   localparam int tx_mode_bit     = 1;
   localparam int clk_sel_bit     = 2;
   localparam int polarity_bit    = 3;
   localparam int data_bit        = 4;
   localparam int reload_bit      = 5;
   localparam int burst_bit       = 6;
   localparam int div_lsb         = 7;
   localparam int edge_lsb        = 9;
   localparam int env_lsb         = 11;
   localparam int ctrl_width      = 13;

   // power control register bits
   localparam int manual_level_bit = 0;
   localparam int manual_oe_bit    = 1;

   // status and mask bits
   localparam int interval_flag_bit = 0;
   localparam int overflow_flag_bit = 1;

   // ------------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------------
   localparam logic [ctrl_width-1:0] ctrl_reset    = 13'h0000;
   localparam logic [15:0]           carrier_reset = 16'h0000;
   localparam logic [15:0]           modtime_reset = 16'h0000;
   localparam logic [15:0]           count_max     = 16'hFFFF;
   localparam logic [1:0]            env_modulated = 2'h1;
   localparam logic [1:0]            env_carrier   = 2'h2;
   localparam logic [1:0]            edge_falling  = 2'h0;
   localparam logic [1:0]            edge_rising   = 2'h1;
   localparam logic [1:0]            space_periods = 2'h2;
   localparam logic [1:0]            htrans_nonseq = 2'h2;

endpackage

// file: sim/ir_timer_sva.sv
/* port checker for the ir timer.
   assumes one clock domain and a single bus master. */
`timescale 1ns/1ps
`default_nettype none
module ir_timer_sva
   import ir_timer_pkg::*;
(
   // clock, reset and bus
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        hsel_in,
   input wire logic [7:0]  haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic        hready_in,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   input wire logic [31:0] hrdata_out,
   // pins
   input wire logic        ir_transmit_pin_out,
   input wire logic        ir_transmit_pin_oe_out,
   input wire logic        irq_out
);
   // ----------------------------------------
   // shadows of the written registers
   // ----------------------------------------
   logic                  wr_reg, rd_reg;
   logic [7:0]            addr_reg;
   logic [ctrl_width-1:0] ctrl_reg;
   logic [1:0]            mask_reg, power_reg;
   logic [2:0]            calm_reg;
   always_ff @(posedge clk_in) begin
      wr_reg   <= rstn_in & hsel_in & htrans_in[1] & hready_in & hwrite_in;
      rd_reg   <= rstn_in & hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
      addr_reg <= haddr_in;
      if (!rstn_in) begin
         ctrl_reg  <= ctrl_reset;
         mask_reg  <= 2'h0;
         power_reg <= 2'h0;
      end else if (wr_reg) begin
         if (addr_reg == ctrl_offset) ctrl_reg <= hwdata_in[ctrl_width-1:0];
         if (addr_reg == mask_offset) mask_reg <= hwdata_in[1:0];
         if (addr_reg == power_offset) power_reg <= hwdata_in[1:0];
      end
   end
   // cycles since the last control or power write
   always_ff @(posedge clk_in) begin
      if (!rstn_in || (wr_reg && (addr_reg == ctrl_offset || addr_reg == power_offset))) begin
         calm_reg <= 3'h0;
      end else if (calm_reg != 3'h7) begin
         calm_reg <= calm_reg + 3'h1;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   ready_high_a: assert property (hreadyout_out)
      else $error("hreadyout low");
   resp_okay_a: assert property (!hresp_out)
      else $error("error response");
   rdata_hold_a: assert property (!rd_reg |-> $stable(hrdata_out))
      else $error("read data moved without a read");
   mask_readback_a: assert property (rd_reg && addr_reg == mask_offset
      |-> hrdata_out == {30'h0, $past(mask_reg)}) else $error("mask read back wrong");
   idle_manual_a: assert property (calm_reg >= 3'h3 && !ctrl_reg[enable_bit]
      |-> ir_transmit_pin_out == power_reg[manual_level_bit]
      && ir_transmit_pin_oe_out == power_reg[manual_oe_bit]) else $error("manual pin wrong");
   rx_idle_level_a: assert property (calm_reg >= 3'h3 && ctrl_reg[enable_bit]
      && !ctrl_reg[tx_mode_bit] |-> ir_transmit_pin_out == ctrl_reg[polarity_bit])
      else $error("idle level wrong");
   irq_masked_a: assert property (mask_reg == 2'h0 |-> !irq_out)
      else $error("irq with mask clear");
   irq_sticky_a: assert property (irq_out && !(wr_reg && (addr_reg == status_offset
      || addr_reg == mask_offset)) |=> irq_out) else $error("irq dropped by itself");
endmodule
bind ir_carrier_modulation_timer ir_timer_sva i_ir_timer_sva (
   .clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
   .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
   .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .hrdata_out(hrdata_out), .ir_transmit_pin_out(ir_transmit_pin_out),
   .ir_transmit_pin_oe_out(ir_transmit_pin_oe_out), .irq_out(irq_out));
`default_nettype wire

// file: sim/ir_link_model.sv
/* infrared led driver and receiver module seen from the pins.
   assumes the receiver output idles high and changes after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module ir_link_model (
   // clock
   input  wire logic clk_in,
   // led drive and receiver output
   input  wire logic led_in,
   output logic      rx_out
);
   logic prev = 1'b0;
   int   run_len = 0, high_len = 0, low_len = 0, toggles = 0;
   initial rx_out = 1'b1;
   // lengths of the last complete high and low runs of the led
   always @(posedge clk_in) begin
      prev <= led_in;
      if (led_in === prev) begin
         run_len <= run_len + 1;
      end else begin
         if (prev) high_len <= run_len;
         else low_len <= run_len;
         run_len <= 1;
         toggles <= toggles + 1;
      end
   end
   // one received mark of n cycles
   task automatic mark(input int n);
      @(posedge clk_in);
      rx_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      rx_out <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// file: sim/ir_carrier_modulation_timer_test.sv
/* self-checking bench for the ir timer.
   assumes the checker is bound and the link model stands at the pins. */
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_modulation_timer_test
   import ir_timer_pkg::*;
   ;
   typedef struct {logic [31:0] exp; logic [31:0] mask; logic [7:0] addr;} note_type;
   logic        clk_in = 1'b0, rstn_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
   logic        hready, hresp, tx_pin, tx_oe, env_pin, irq, rx_pin;
   logic [1:0]  htrans = 2'h0;
   logic [7:0]  haddr = 8'h00, hb, lb;
   logic [31:0] hwdata = 32'h0, hrdata;
   int          n_fail = 0, checks = 0, seed, n, t0, p, d, dv;
   note_type    notes[$];
   always #20 clk_in = ~clk_in;
   ir_carrier_modulation_timer i_ir_carrier_modulation_timer (
      .clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
      .ir_receive_pin_in(rx_pin), .ir_transmit_pin_out(tx_pin),
      .ir_transmit_pin_oe_out(tx_oe), .envelope_output_pin_out(env_pin), .irq_out(irq));
   ir_link_model i_ir_link_model (.clk_in(clk_in), .led_in(tx_pin), .rx_out(rx_pin));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic guard(inout int c, input int lim);
      c++;
      if (c > lim) begin
         n_fail++;
         end_of_test();
      end else begin
         @(posedge clk_in);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
      int c;
      @(posedge clk_in);
      hsel   <= 1'b1;
      htrans <= htrans_nonseq;
      hwrite <= w;
      haddr  <= a;
      c = 0;
      do guard(c, 50); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dat;
      rd_ph  <= ~w;
      c = 0;
      do guard(c, 50); while (hready !== 1'b1);
      rd_ph <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      bus(1'b1, a, dat);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      notes.push_back('{e, m, a});
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wait_tog(input int k);
      int c;
      c = 0;
      t0 = i_ir_link_model.toggles;
      while (i_ir_link_model.toggles < t0 + k) guard(c, 3000);
   endtask
   // read results are compared against the oldest note
   always @(posedge clk_in) begin
      if (rd_ph) begin
         note_type nt;
         nt = notes.pop_front();
         check($sformatf("read %h", nt.addr), hrdata & nt.mask, nt.exp);
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      seed = $urandom(92);
      for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0, 32'hFFFFFFFF);
      $display("test reset done");
      for (int v = 0; v < 4; v++) begin
         wr(power_offset, v);
         repeat (3) @(negedge clk_in);
         check("tx pin", 32'(tx_pin), v & 1);
         check("tx oe", 32'(tx_oe), v >> 1);
      end
      wr(power_offset, 32'h0);
      $display("test manual done");
      hb = 8'($urandom_range(3, 0));
      lb = 8'($urandom_range(3, 0));
      dv = $urandom_range(1, 0);
      wr(carrier_offset, {16'h0, hb, lb});
      wr(modtime_offset, 32'd60);
      for (int k = 0; k < 5; k++) begin
         p = k & 1;
         d = (k >> 1) & 1;
         wr(ctrl_offset, 32'h0);
         wr(ctrl_offset, (((k == 4) ? 2 : 1) << env_lsb) | (dv << div_lsb) | (d << data_bit)
            | (p << polarity_bit) | 3);
         if (d || k == 4) begin
            wait_tog(5);
            n = ((p ? lb : hb) + 1) << dv;
            check("high run", i_ir_link_model.high_len, n);
            n = ((p ? hb : lb) + 1) << dv;
            check("low run", i_ir_link_model.low_len, n);
         end else begin
            repeat (4) @(negedge clk_in);
            t0 = i_ir_link_model.toggles;
            repeat (100) @(negedge clk_in);
            check("idle toggles", i_ir_link_model.toggles - t0, 0);
            check("idle level", 32'(tx_pin), p);
         end
         @(negedge clk_in);
         check("envelope", 32'(env_pin), d ^ p);
      end
      $display("test carrier done");
      wr(ctrl_offset, 32'h0);
      wr(carrier_offset, 32'h0);
      wr(modtime_offset, 32'h3);
      wr(status_offset, 32'h3);
      wr(ctrl_offset, (1 << data_bit) | (1 << clk_sel_bit) | 3);
      repeat (20) @(posedge clk_in);
      wr(ctrl_offset, 32'h0);
      rd(status_offset, 32'h1, 32'h1);
      wr(status_offset, 32'h0);
      rd(status_offset, 32'h1, 32'h1);
      wr(mask_offset, 32'h1);
      @(negedge clk_in);
      check("irq", 32'(irq), 1);
      wr(status_offset, 32'h1);
      rd(status_offset, 32'h0, 32'h1);
      @(negedge clk_in);
      check("irq cleared", 32'(irq), 0);
      $display("test interval done");
      wr(ctrl_offset, (2 << edge_lsb) | (1 << reload_bit) | (1 << clk_sel_bit) | 1);
      i_ir_link_model.mark(31);
      repeat (10) @(posedge clk_in);
      rd(modtime_offset, 32'd30, 32'hFFFFFFFF);
      rd(ctrl_offset, 1 << data_bit, 1 << data_bit);
      wr(status_offset, 32'h3);
      wr(mask_offset, 32'h2);
      n = 0;
      while (irq !== 1'b1) guard(n, 70000);
      rd(status_offset, 32'h2, 32'h2);
      $display("test receive done");
      wr(ctrl_offset, (1 << edge_lsb) | (1 << burst_bit) | (1 << reload_bit) | 1);
      wr(modtime_offset, 32'h0);
      wr(status_offset, 32'h3);
      repeat (3) i_ir_link_model.mark(2);
      repeat (20) @(posedge clk_in);
      rd(modtime_offset, 32'd3, 32'hFFFFFFFF);
      rd(status_offset, 32'h1, 32'h1);
      $display("test burst done");
      end_of_test();
   end
endmodule
`default_nettype wire
